// ==== hw/wtlpc_pkg.sv ====
// package: register map, field positions, reset values and timing of the wake-up timer block
package wtlpc_pkg;
    localparam logic [10:0] ADDR_IRQ_ENABLE_LO = 11'h100;
    localparam logic [10:0] ADDR_IRQ_ENABLE_HI = 11'h101;
    localparam logic [10:0] ADDR_WAKE_COUNT_LO = 11'h102;
    localparam logic [10:0] ADDR_WAKE_COUNT_HI = 11'h103;
    localparam logic [10:0] ADDR_WAKE_LIMIT_LO = 11'h104;
    localparam logic [10:0] ADDR_WAKE_LIMIT_HI = 11'h105;
    localparam logic [10:0] ADDR_LISTEN_WINDOW_LEN = 11'h106;
    localparam logic [10:0] ADDR_LISTEN_TICK_DIVIDER = 11'h107;
    localparam logic [10:0] ADDR_SIGNAL_LEVEL_LIMIT = 11'h108;
    localparam logic [10:0] ADDR_OPERATING_MODE_CTL = 11'h11a;
    localparam logic [10:0] ADDR_WAKE_TIMER_CFG_HI = 11'h30c;
    localparam logic [10:0] ADDR_WAKE_TIMER_CFG_LO = 11'h30d;
    localparam logic [10:0] ADDR_WAKE_TIMER_LOAD_HI = 11'h30e;
    localparam logic [10:0] ADDR_WAKE_TIMER_LOAD_LO = 11'h30f;
    // irq_enable_lo fields
    localparam int BIT_WAKE_COUNT_IRQ_EN = 0;
    localparam int BIT_LEVEL_DETECT_IRQ_EN = 1;
    localparam int BIT_PREAMBLE_IRQ_EN = 2;
    localparam int BIT_SYNC_IRQ_EN = 3;
    localparam int BIT_ADDR_MATCH_IRQ_EN = 4;
    // irq_enable_hi fields
    localparam int BIT_WAKE_TIMEOUT_IRQ_EN = 0;
    // operating_mode_ctl fields
    localparam int BIT_AUTONOMOUS_LISTEN_ON = 0;
    localparam int BIT_LEVEL_PREQUAL_ON = 1;
    // wake_timer_cfg_hi fields
    localparam int POS_WAKE_TIMER_DIV_SEL = 0;
    localparam int WID_WAKE_TIMER_DIV_SEL = 3;
    // wake_timer_cfg_lo fields
    localparam int BIT_BACKUP_RAM_KEEP = 0;
    localparam int BIT_RC_OSC_ON = 1;
    localparam int BIT_CRYSTAL_OSC_ON = 2;
    localparam int POS_WAKE_CLK_SRC = 3;
    localparam int WID_WAKE_CLK_SRC = 2;
    localparam int BIT_WAKE_TIMER_ARMED = 5;
    localparam logic [1:0] CLK_SRC_RC = 2'h1;
    localparam logic [1:0] CLK_SRC_CRYSTAL = 2'h2;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // rssi register value minus this offset is the level in dBm
    localparam int LEVEL_DBM_OFFSET = 107;
    // listen tick is derived from this clock divided by 128 times the divider
    localparam int LISTEN_BASE_HZ = 6_500_000;
    localparam int LISTEN_BASE_DIV = 128;
    localparam int MCLK_HZ = 100_000_000;
    localparam int LISTEN_BASE_CYCLES = (MCLK_HZ / LISTEN_BASE_HZ) * LISTEN_BASE_DIV;
    typedef enum logic [2:0] {
        WTLPC_OFF = 3'b000,
        WTLPC_SLEEP = 3'b001,
        WTLPC_WAKE = 3'b010,
        WTLPC_LISTEN = 3'b011,
        WTLPC_ON = 3'b100
    } wtlpc_state_t;
endpackage : wtlpc_pkg

// ==== hw/wtlpc_prescaler.sv ====
// prescaler: divides the selected 32.768 kHz tick by 2^(sel+1)
`timescale 1ns/1ps
module wtlpc_prescaler #(
    parameter int SEL_W = 3
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_clear,
    input wire logic i_tick,
    input wire logic [SEL_W-1:0] i_sel,
    output logic o_tick
);
    logic [8:0] count;
    wire [8:0] limit = 9'((9'h002 << i_sel) - 9'h001);
    wire hit = i_tick && (count >= limit);
    always_ff @(posedge i_mclk) begin
        if (i_reset || i_clear) begin
            count <= 9'h000;
        end else if (hit) begin
            count <= 9'h000;
        end else if (i_tick) begin
            count <= 9'(count + 9'h001);
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_reset || i_clear) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= hit;
        end
    end
endmodule : wtlpc_prescaler

// ==== hw/wtlpc_top.sv ====
// wake-up timer and low power control: registers, hw timer, wake counter, autonomous listen
// Functional notes
// - 16-bit wake timer behind programmable prescaler
// - wake counter increments once per timer timeout in sleep while count irq enable is set
// - backup ram keep bit controls retention
// - 3-bit prescaler field selects clock division
// - separate rc and crystal oscillator enables
// - clock source 1 rc, 2 crystal
// - timeout wakes from sleep only when armed
// - interval is load times 2^(div+1) ticks
// - timeout irq enable in high mask
// - count irq enable runs counter, fires above limit
// - wake count readable as two bytes
// - count above limit leaves low power mode
// - mode bit enables autonomous listen
// - mode bit enables level prequalification
// - level limit means register minus 107 dBm
// - divider sets listen tick rate
// - window length times tick sets listen time
// - four listen interrupt enables in low mask
// - listen wakes autonomously, interrupts only when qualified
// - return to sleep while count not above limit
// - low level sleeps, high level interrupts, waits on
`timescale 1ns/1ps
module wtlpc_top #(
    parameter int TIMER_W = 16,
    parameter int DIV_W = 3
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [10:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    input wire logic i_enter_sleep,
    input wire logic i_host_cmd,
    input wire logic i_rc_tick,
    input wire logic i_crystal_tick,
    input wire logic [7:0] i_level,
    input wire logic i_level_valid,
    input wire logic i_preamble,
    input wire logic i_sync,
    input wire logic i_addr_match,
    input wire logic i_packet_busy,
    output logic o_irq,
    output logic o_rc_osc_on,
    output logic o_crystal_osc_on,
    output logic o_backup_ram_keep,
    output logic o_receiver_on,
    output logic o_level_measure,
    output logic [wtlpc_pkg::WID_WAKE_CLK_SRC-1:0] o_wake_clk_src,
    output wtlpc_pkg::wtlpc_state_t o_state
);
    import wtlpc_pkg::*;

    logic [7:0] irq_enable_lo;
    logic [7:0] irq_enable_hi;
    logic [15:0] wake_count;
    logic [15:0] wake_limit;
    logic [7:0] listen_window_len;
    logic [7:0] listen_tick_divider;
    logic [7:0] signal_level_limit;
    logic [7:0] operating_mode_ctl;
    logic [7:0] wake_timer_cfg_hi;
    logic [7:0] wake_timer_cfg_lo;
    logic [15:0] wake_timer_load;
    logic [7:0] load_hi_stage;
    logic [7:0] cfg_hi_stage;
    logic [TIMER_W-1:0] wake_timer;
    logic [15:0] base_count;
    logic [7:0] tick_count;
    logic [7:0] window_count;
    logic irq_pending;
    wtlpc_state_t state;
    wtlpc_state_t next_state;

    // register write strobes
    wire wr_en_lo = i_wr && (i_addr == ADDR_IRQ_ENABLE_LO);
    wire wr_en_hi = i_wr && (i_addr == ADDR_IRQ_ENABLE_HI);
    wire wr_cnt_lo = i_wr && (i_addr == ADDR_WAKE_COUNT_LO);
    wire wr_cnt_hi = i_wr && (i_addr == ADDR_WAKE_COUNT_HI);
    wire wr_lim_lo = i_wr && (i_addr == ADDR_WAKE_LIMIT_LO);
    wire wr_lim_hi = i_wr && (i_addr == ADDR_WAKE_LIMIT_HI);
    wire wr_win = i_wr && (i_addr == ADDR_LISTEN_WINDOW_LEN);
    wire wr_div = i_wr && (i_addr == ADDR_LISTEN_TICK_DIVIDER);
    wire wr_lvl = i_wr && (i_addr == ADDR_SIGNAL_LEVEL_LIMIT);
    wire wr_mode = i_wr && (i_addr == ADDR_OPERATING_MODE_CTL);
    wire wr_cfg_hi = i_wr && (i_addr == ADDR_WAKE_TIMER_CFG_HI);
    wire wr_cfg_lo = i_wr && (i_addr == ADDR_WAKE_TIMER_CFG_LO);
    wire wr_load_hi = i_wr && (i_addr == ADDR_WAKE_TIMER_LOAD_HI);
    wire wr_load_lo = i_wr && (i_addr == ADDR_WAKE_TIMER_LOAD_LO);

    // configuration fields
    wire [DIV_W-1:0] div_sel = wake_timer_cfg_hi[POS_WAKE_TIMER_DIV_SEL +: DIV_W];
    wire [1:0] clk_src = wake_timer_cfg_lo[POS_WAKE_CLK_SRC +: WID_WAKE_CLK_SRC];
    wire rc_osc_on = wake_timer_cfg_lo[BIT_RC_OSC_ON];
    wire crystal_osc_on = wake_timer_cfg_lo[BIT_CRYSTAL_OSC_ON];
    wire armed = wake_timer_cfg_lo[BIT_WAKE_TIMER_ARMED];
    wire listen_on = operating_mode_ctl[BIT_AUTONOMOUS_LISTEN_ON];
    wire prequal_on = operating_mode_ctl[BIT_LEVEL_PREQUAL_ON];
    wire count_irq_en = irq_enable_lo[BIT_WAKE_COUNT_IRQ_EN];
    wire timeout_irq_en = irq_enable_hi[BIT_WAKE_TIMEOUT_IRQ_EN];

    // a source only ticks while its oscillator is enabled
    wire src_tick = (clk_src == CLK_SRC_RC) ? (i_rc_tick && rc_osc_on) :
                    (clk_src == CLK_SRC_CRYSTAL) ? (i_crystal_tick && crystal_osc_on) : 1'b0;
    wire timer_tick;
    wire timer_clear = wr_load_lo || wr_cfg_lo;

    wtlpc_prescaler #(
        .SEL_W(DIV_W)
    ) u_prescaler (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_clear(timer_clear),
        .i_tick(src_tick),
        .i_sel(div_sel),
        .o_tick(timer_tick)
    );

    wire timer_running = armed && (state != WTLPC_OFF);
    wire timeout = timer_running && timer_tick && (wake_timer <= TIMER_W'(1));
    wire sleep_timeout = timeout && (state == WTLPC_SLEEP) && armed;
    wire [15:0] count_inc = 16'(wake_count + 16'h0001);
    wire over_limit = count_irq_en && (count_inc > wake_limit);

    // listen window timing: one tick every 128 * divider base periods
    wire base_hit = (base_count >= 16'(LISTEN_BASE_CYCLES - 1));
    wire listen_tick = base_hit && (tick_count + 8'h01 >= listen_tick_divider);
    wire window_done = (window_count >= listen_window_len) && !i_packet_busy;
    wire level_high = i_level_valid && (i_level > signal_level_limit);
    wire rx_event = (i_preamble && irq_enable_lo[BIT_PREAMBLE_IRQ_EN]) ||
                    (i_sync && irq_enable_lo[BIT_SYNC_IRQ_EN]) ||
                    (i_addr_match && irq_enable_lo[BIT_ADDR_MATCH_IRQ_EN]);
    wire level_irq = level_high && irq_enable_lo[BIT_LEVEL_DETECT_IRQ_EN];

    // irq events
    wire irq_set = (sleep_timeout && timeout_irq_en) ||
                   (sleep_timeout && over_limit) ||
                   ((state == WTLPC_WAKE) && prequal_on && level_irq && i_level_valid) ||
                   ((state == WTLPC_LISTEN) && (rx_event || (prequal_on && level_irq)));

    always_comb begin
        next_state = state;
        case (state)
            WTLPC_OFF: begin
                if (i_enter_sleep) begin
                    next_state = WTLPC_SLEEP;
                end
            end
            WTLPC_SLEEP: begin
                if (sleep_timeout && over_limit) begin
                    next_state = WTLPC_OFF;
                end else if (sleep_timeout && listen_on) begin
                    next_state = prequal_on ? WTLPC_WAKE : WTLPC_LISTEN;
                end
            end
            WTLPC_WAKE: begin
                if (i_level_valid) begin
                    next_state = level_high ? WTLPC_ON : WTLPC_SLEEP;
                end
            end
            WTLPC_LISTEN: begin
                if (rx_event) begin
                    next_state = WTLPC_ON;
                end else if (window_done) begin
                    next_state = WTLPC_SLEEP;
                end
            end
            WTLPC_ON: begin
                if (i_host_cmd) begin
                    next_state = i_enter_sleep ? WTLPC_SLEEP : WTLPC_OFF;
                end
            end
            default: begin
                next_state = WTLPC_OFF;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state <= WTLPC_OFF;
        end else begin
            state <= next_state;
        end
    end

    // hw wake timer: reloads on every timeout
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wake_timer <= TIMER_W'(0);
        end else if (timer_clear || !timer_running) begin
            wake_timer <= TIMER_W'(wake_timer_load);
        end else if (timeout) begin
            wake_timer <= TIMER_W'(wake_timer_load);
        end else if (timer_tick) begin
            wake_timer <= TIMER_W'(wake_timer - TIMER_W'(1));
        end
    end

    // wake counter, only while its interrupt enable is set
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wake_count <= COUNT_RESET;
        end else if (sleep_timeout && count_irq_en) begin
            wake_count <= count_inc;
        end else if (wr_cnt_lo) begin
            wake_count[7:0] <= i_wdata;
        end else if (wr_cnt_hi) begin
            wake_count[15:8] <= i_wdata;
        end
    end

    // listen window counters run only inside the listen state
    always_ff @(posedge i_mclk) begin
        if (i_reset || (state != WTLPC_LISTEN)) begin
            base_count <= 16'h0000;
            tick_count <= 8'h00;
            window_count <= 8'h00;
        end else begin
            base_count <= base_hit ? 16'h0000 : 16'(base_count + 16'h0001);
            if (listen_tick) begin
                tick_count <= 8'h00;
                window_count <= (window_count == 8'hff) ? window_count : 8'(window_count + 8'h01);
            end else if (base_hit) begin
                tick_count <= 8'(tick_count + 8'h01);
            end
        end
    end

    // wake timer byte pairs: high byte is staged and committed with the low byte
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            cfg_hi_stage <= REG_RESET;
            load_hi_stage <= REG_RESET;
            wake_timer_cfg_hi <= REG_RESET;
            wake_timer_cfg_lo <= REG_RESET;
            wake_timer_load <= COUNT_RESET;
        end else begin
            if (wr_cfg_hi) begin
                cfg_hi_stage <= i_wdata;
            end
            if (wr_cfg_lo) begin
                wake_timer_cfg_hi <= cfg_hi_stage;
                wake_timer_cfg_lo <= i_wdata;
            end
            if (wr_load_hi) begin
                load_hi_stage <= i_wdata;
            end
            if (wr_load_lo) begin
                wake_timer_load <= {load_hi_stage, i_wdata};
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            irq_enable_lo <= REG_RESET;
            irq_enable_hi <= REG_RESET;
            wake_limit <= COUNT_RESET;
            listen_window_len <= REG_RESET;
            listen_tick_divider <= REG_RESET;
            signal_level_limit <= REG_RESET;
            operating_mode_ctl <= REG_RESET;
        end else begin
            if (wr_en_lo) begin
                irq_enable_lo <= i_wdata;
            end
            if (wr_en_hi) begin
                irq_enable_hi <= i_wdata;
            end
            if (wr_lim_lo) begin
                wake_limit[7:0] <= i_wdata;
            end
            if (wr_lim_hi) begin
                wake_limit[15:8] <= i_wdata;
            end
            if (wr_win) begin
                listen_window_len <= i_wdata;
            end
            if (wr_div) begin
                listen_tick_divider <= i_wdata;
            end
            if (wr_lvl) begin
                signal_level_limit <= i_wdata;
            end
            if (wr_mode) begin
                operating_mode_ctl <= i_wdata;
            end
        end
    end

    // interrupt: set wins over the host acknowledge
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            irq_pending <= 1'b0;
        end else if (irq_set) begin
            irq_pending <= 1'b1;
        end else if (i_host_cmd) begin
            irq_pending <= 1'b0;
        end
    end

    // read mux, unmapped addresses read zero
    wire [7:0] rd_mux =
        (i_addr == ADDR_IRQ_ENABLE_LO) ? irq_enable_lo :
        (i_addr == ADDR_IRQ_ENABLE_HI) ? irq_enable_hi :
        (i_addr == ADDR_WAKE_COUNT_LO) ? wake_count[7:0] :
        (i_addr == ADDR_WAKE_COUNT_HI) ? wake_count[15:8] :
        (i_addr == ADDR_WAKE_LIMIT_LO) ? wake_limit[7:0] :
        (i_addr == ADDR_WAKE_LIMIT_HI) ? wake_limit[15:8] :
        (i_addr == ADDR_LISTEN_WINDOW_LEN) ? listen_window_len :
        (i_addr == ADDR_LISTEN_TICK_DIVIDER) ? listen_tick_divider :
        (i_addr == ADDR_SIGNAL_LEVEL_LIMIT) ? signal_level_limit :
        (i_addr == ADDR_OPERATING_MODE_CTL) ? operating_mode_ctl :
        (i_addr == ADDR_WAKE_TIMER_CFG_HI) ? wake_timer_cfg_hi :
        (i_addr == ADDR_WAKE_TIMER_CFG_LO) ? wake_timer_cfg_lo :
        (i_addr == ADDR_WAKE_TIMER_LOAD_HI) ? wake_timer_load[15:8] :
        (i_addr == ADDR_WAKE_TIMER_LOAD_LO) ? wake_timer_load[7:0] : 8'h00;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rdata <= REG_RESET;
            o_rvalid <= 1'b0;
        end else begin
            o_rdata <= i_rd ? rd_mux : o_rdata;
            o_rvalid <= i_rd;
        end
    end

    assign o_irq = irq_pending;
    assign o_rc_osc_on = rc_osc_on;
    assign o_crystal_osc_on = crystal_osc_on;
    // keep bit is honoured by the ram power switch during sleep
    assign o_backup_ram_keep = wake_timer_cfg_lo[BIT_BACKUP_RAM_KEEP];
    assign o_receiver_on = (state == WTLPC_LISTEN) || (state == WTLPC_WAKE);
    assign o_level_measure = (state == WTLPC_WAKE);
    assign o_wake_clk_src = clk_src;
    assign o_state = state;
endmodule : wtlpc_top

// ==== verification/wtlpc_chk.sv ====
// checker: port-level properties of the wake-up timer block
`timescale 1ns/1ps
module wtlpc_chk (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [10:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_enter_sleep,
    input wire logic i_host_cmd,
    input wire logic i_level_valid,
    input wire logic o_irq,
    input wire logic o_rc_osc_on,
    input wire logic o_crystal_osc_on,
    input wire logic o_backup_ram_keep,
    input wire logic o_receiver_on,
    input wire logic o_level_measure,
    input wire logic [wtlpc_pkg::WID_WAKE_CLK_SRC-1:0] o_wake_clk_src,
    input wire wtlpc_pkg::wtlpc_state_t o_state
);
    import wtlpc_pkg::*;
    wire cfg_lo_wr = i_wr && (i_addr == ADDR_WAKE_TIMER_CFG_LO);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    AST_READ_ANSWER: assert property (i_rd |=> o_rvalid)
        else $error("read not answered in the next cycle");
    AST_READ_HOLD: assert property (!o_rvalid |-> $stable(o_rdata))
        else $error("read data moved without a read");
    AST_OSC_EN: assert property (cfg_lo_wr |=> {o_crystal_osc_on, o_rc_osc_on} == $past(i_wdata[2:1]))
        else $error("oscillator enables do not follow the config write");
    AST_CLK_SRC: assert property (cfg_lo_wr |=> o_wake_clk_src == $past(i_wdata[4:3]))
        else $error("clock source does not follow the config write");
    AST_RAM_KEEP: assert property (cfg_lo_wr |=> o_backup_ram_keep == $past(i_wdata[0]))
        else $error("retention bit does not follow the config write");
    AST_MEASURE: assert property (o_level_measure == (o_state == WTLPC_WAKE))
        else $error("level measure not tied to the level check state");
    AST_RECEIVER: assert property (o_receiver_on == (o_state inside {WTLPC_WAKE, WTLPC_LISTEN}))
        else $error("receiver enable not tied to the awake states");
    AST_LEVEL_DONE: assert property (o_state == WTLPC_WAKE && i_level_valid |=> o_state inside {WTLPC_ON, WTLPC_SLEEP})
        else $error("level result did not end the level check");
    AST_IRQ_HOLD: assert property (o_irq && !i_host_cmd |=> o_irq)
        else $error("interrupt dropped without acknowledge");
    AST_OFF_EXIT: assert property (o_state != WTLPC_OFF && $past(o_state) == WTLPC_OFF |-> $past(i_enter_sleep))
        else $error("left the off state without a sleep command");
endmodule : wtlpc_chk

// ==== verification/wtlpc_osc_model.sv ====
// oscillator model: one-cycle ticks from each low-rate oscillator while it is enabled
`timescale 1ns/1ps
module wtlpc_osc_model #(
    parameter int RC_PERIOD = 8,
    parameter int XO_PERIOD = 12
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_rc_osc_on,
    input wire logic i_crystal_osc_on,
    output logic o_rc_tick,
    output logic o_crystal_tick
);
    // a true 32.768 kHz period is some 3052 cycles; shortened so a run stays brief
    int rc_cnt;
    int xo_cnt;
    always_ff @(posedge i_mclk) begin
        if (i_reset || !i_rc_osc_on) begin
            rc_cnt <= 0;
            o_rc_tick <= 1'b0;
        end else begin
            rc_cnt <= (rc_cnt == RC_PERIOD - 1) ? 0 : rc_cnt + 1;
            o_rc_tick <= (rc_cnt == RC_PERIOD - 1);
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_reset || !i_crystal_osc_on) begin
            xo_cnt <= 0;
            o_crystal_tick <= 1'b0;
        end else begin
            xo_cnt <= (xo_cnt == XO_PERIOD - 1) ? 0 : xo_cnt + 1;
            o_crystal_tick <= (xo_cnt == XO_PERIOD - 1);
        end
    end
endmodule : wtlpc_osc_model

// ==== verification/tb.sv ====
// testbench: registers, wake timer, wake counter and autonomous listen
`timescale 1ns/1ps
module tb;
    import wtlpc_pkg::*;
    localparam int TICK = 8;
    typedef struct packed { logic [10:0] a; logic [7:0] d; } wtlpc_row_t;
    logic i_mclk, i_reset, i_wr, i_rd, i_rc_tick, i_crystal_tick, i_packet_busy, i_level_valid;
    logic i_enter_sleep, i_host_cmd, i_preamble, i_sync, i_addr_match, o_rvalid, o_irq;
    logic o_rc_osc_on, o_crystal_osc_on, o_backup_ram_keep, o_receiver_on, o_level_measure;
    logic [10:0] i_addr;
    logic [7:0] i_wdata, i_level, o_rdata, rd_val;
    logic [5:0] ev;
    logic [1:0] o_wake_clk_src;
    wtlpc_state_t o_state;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    int t0;
    wtlpc_row_t rows [14] = '{'{11'h100, 8'h5a}, '{11'h101, 8'h01}, '{11'h102, 8'h34}, '{11'h103, 8'h12},
        '{11'h104, 8'h78}, '{11'h105, 8'h56}, '{11'h106, 8'h9a}, '{11'h107, 8'hbc}, '{11'h108, 8'hde},
        '{11'h11a, 8'h03}, '{11'h30c, 8'h05}, '{11'h30d, 8'h16}, '{11'h30e, 8'hab}, '{11'h30f, 8'hcd}};
    assign {i_addr_match, i_sync, i_preamble, i_level_valid, i_host_cmd, i_enter_sleep} = ev;
    wtlpc_top dut (.*);
    wtlpc_osc_model #(.RC_PERIOD(TICK), .XO_PERIOD(12)) u_osc (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_rc_osc_on(o_rc_osc_on), .i_crystal_osc_on(o_crystal_osc_on), .o_rc_tick(i_rc_tick),
        .o_crystal_tick(i_crystal_tick));
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) cyc++;
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [10:0] a);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        chk("read valid", o_rvalid, 1'b1);
        rd_val = o_rdata;
    endtask : rd
    // event pins share one vector so each pulse is a single assignment per edge
    task automatic pulse(input logic [5:0] m);
        @(posedge i_mclk);
        ev <= m;
        @(posedge i_mclk);
        ev <= 6'h00;
    endtask : pulse
    task automatic wait_st(input wtlpc_state_t s, input int lim);
        // step off the launching edge so the state is settled before it is looked at
        #1;
        for (int k = 0; k < lim && o_state !== s; k++) begin
            @(posedge i_mclk);
            #1;
        end
        chk("state", o_state, 16'(s));
    endtask : wait_st
    task automatic wait_irq(input int lim);
        int k = 0;
        do begin
            @(posedge i_mclk);
            #1;
            k++;
        end while (o_irq !== 1'b1 && k < lim);
        chk("irq raised", o_irq, 1'b1);
    endtask : wait_irq
    task automatic do_reset;
        @(posedge i_mclk);
        i_reset <= 1'b1;
        repeat (10) @(posedge i_mclk);
        i_reset <= 1'b0;
    endtask : do_reset
    task automatic setup(input logic [7:0] lo, hi, mode, cfg, lim);
        wr(ADDR_IRQ_ENABLE_LO, lo);
        wr(ADDR_IRQ_ENABLE_HI, hi);
        wr(ADDR_WAKE_LIMIT_LO, lim);
        wr(ADDR_OPERATING_MODE_CTL, mode);
        wr(ADDR_SIGNAL_LEVEL_LIMIT, 8'h50);
        wr(ADDR_LISTEN_WINDOW_LEN, 8'h01);
        wr(ADDR_LISTEN_TICK_DIVIDER, 8'h01);
        wr(ADDR_WAKE_TIMER_CFG_HI, 8'h01);
        wr(ADDR_WAKE_TIMER_CFG_LO, cfg);
        wr(ADDR_WAKE_TIMER_LOAD_HI, 8'h00);
        wr(ADDR_WAKE_TIMER_LOAD_LO, 8'h03);
    endtask : setup
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (30000) @(posedge i_mclk);
        n_errors++;
        $display("watchdog expired");
        wrap_up();
    end
    initial begin
        {i_reset, i_wr, i_rd, i_addr, i_wdata, i_level, i_packet_busy, ev} = '0;
        i_reset = 1'b1;
        do_reset();
        foreach (rows[k]) begin
            rd(rows[k].a);
            chk("reset value", rd_val, REG_RESET);
        end
        rd(11'h200);
        chk("unmapped read", rd_val, 8'h00);
        foreach (rows[k]) wr(rows[k].a, rows[k].d);
        foreach (rows[k]) begin
            rd(rows[k].a);
            chk("readback", rd_val, rows[k].d);
        end
        chk("clock source", o_wake_clk_src, CLK_SRC_CRYSTAL);
        chk("crystal enable", o_crystal_osc_on, 1'b1);
        $display("test registers done");
        do_reset();
        wr(ADDR_WAKE_TIMER_CFG_HI, 8'h01);
        rd(ADDR_WAKE_TIMER_CFG_HI);
        chk("staged high", rd_val, 8'h00);
        setup(8'h01, 8'h01, 8'h00, 8'h2b, 8'h01);
        chk("rc enable", o_rc_osc_on, 1'b1);
        chk("ram keep", o_backup_ram_keep, 1'b1);
        chk("clock source", o_wake_clk_src, CLK_SRC_RC);
        pulse(6'h01);
        wait_st(WTLPC_SLEEP, 4);
        wait_irq(400);
        t0 = cyc;
        chk("count at limit", o_state, WTLPC_SLEEP);
        pulse(6'h02);
        wait_irq(400);
        chk("interval", 16'(cyc - t0), 16'(3 * (2 ** 2) * TICK));
        wait_st(WTLPC_OFF, 3);
        rd(ADDR_WAKE_COUNT_LO);
        chk("wake count", rd_val, 8'h02);
        wr(ADDR_WAKE_TIMER_CFG_HI, 8'h01);
        wr(ADDR_WAKE_TIMER_CFG_LO, 8'h0b);
        pulse(6'h02);
        pulse(6'h01);
        repeat (300) @(posedge i_mclk);
        chk("unarmed sleep", o_state, WTLPC_SLEEP);
        $display("test wake timer done");
        do_reset();
        setup(8'h03, 8'h00, 8'h03, 8'h2b, 8'h10);
        pulse(6'h01);
        wait_st(WTLPC_WAKE, 200);
        @(posedge i_mclk);
        i_level <= 8'h4f;
        pulse(6'h04);
        wait_st(WTLPC_SLEEP, 3);
        chk("low level irq", o_irq, 1'b0);
        wait_st(WTLPC_WAKE, 200);
        @(posedge i_mclk);
        i_level <= 8'h51;
        pulse(6'h04);
        wait_st(WTLPC_ON, 3);
        chk("level irq", o_irq, 1'b1);
        $display("test level check done");
        for (int k = 0; k < 3; k++) begin
            do_reset();
            setup(8'(4 << k), 8'h00, 8'h01, 8'h2b, 8'h10);
            pulse(6'h01);
            wait_st(WTLPC_LISTEN, 200);
            chk("receiver on", o_receiver_on, 1'b1);
            pulse(6'(8 << ((k + 1) % 3)));
            repeat (2) @(posedge i_mclk);
            #1;
            chk("masked event", o_irq, 1'b0);
            pulse(6'(8 << k));
            wait_st(WTLPC_ON, 3);
            chk("event irq", o_irq, 1'b1);
        end
        do_reset();
        setup(8'h00, 8'h00, 8'h01, 8'h2b, 8'h10);
        pulse(6'h01);
        wait_st(WTLPC_LISTEN, 200);
        t0 = cyc;
        wait_st(WTLPC_SLEEP, 2000);
        // one tick at divider 1 for a window of 1, plus the edge that leaves the state
        chk("listen window", 16'(cyc - t0), 16'(LISTEN_BASE_CYCLES + 1));
        chk("quiet window irq", o_irq, 1'b0);
        $display("test listen done");
        wrap_up();
    end
endmodule : tb
bind wtlpc_top wtlpc_chk u_chk (.*);
